// ===== verilog/step_timer_defs.vh
// Register offsets, field positions, reset values and timing counts for the step engine
`ifndef STEP_TIMER_DEFS_VH
`define STEP_TIMER_DEFS_VH
`define OFF_CTRL 12'h000
`define OFF_PERIOD 12'h004
`define OFF_STEPS 12'h008
`define OFF_ITERS 12'h00C
`define OFF_STATUS 12'h010
`define OFF_CMD 12'h014
`define OFF_STEPCFG 12'h018
`define OFF_SETUP 12'h01C
`define OFF_PROPTIME 12'h020
`define OFF_RANGETIME 12'h024
`define CTRL_TIMED 0
`define CTRL_OUTPUT_ENABLE 1
`define CTRL_PULSED 2
`define CMD_START 0
`define CMD_ABORT 1
`define CMD_CHAN_RESET 2
`define ST_BUSY 0
`define ST_ERR 1
`define ST_DONE 2
`define ST_CFG_ERR 3
`define CTRL_RST 32'h00000000
`define PERIOD_RST 32'h00000100
`define STEPS_RST 16'h0001
`define ITERS_RST 16'h0001
`define SETUP_RST 16'h0004
`define PROPTIME_RST 16'h0002
`define RANGETIME_RST 16'h0010
`define STEPCFG_RANGE_LSB 0
`define STEPCFG_RANGE_MSB 3
`define STEPCFG_PROPS_LSB 4
`define STEPCFG_PROPS_MSB 7
`define STEPCFG_DELAY_LSB 8
`define STEPCFG_DELAY_MSB 23
`define STEPCFG_MEAS_LSB 24
`define STEPCFG_MEAS_MSB 31
`define MAX_STEPS 16
`endif

// ===== verilog/step_down_counter.v
// Loadable down-counter that pulses when its count runs out
`timescale 1ns/10ps
module step_down_counter (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [31:0] value,
  input wire clear,
  output reg busy,
  output reg expired
);
  reg [31:0] cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h00000000;
      busy <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (clear) begin
        busy <= 1'b0;
        cnt_q <= 32'h00000000;
      end else if (load) begin
        // Zero-length work still takes one cycle
        cnt_q <= (value == 32'h00000000) ? 32'h00000001 : value;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_q == 32'h00000001) begin
          busy <= 1'b0;
          expired <= 1'b1;
        end
        cnt_q <= cnt_q - 32'h00000001;
      end
    end
  end
endmodule

// ===== verilog/period_counter.v
// Saturating up-counter of cycles since the start of the current step, counting only while run is high
`timescale 1ns/10ps
module period_counter (
  input wire pclk,
  input wire presetn,
  input wire restart,
  input wire run,
  output reg [31:0] count
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h00000000;
    end else if (restart) begin
      count <= 32'h00000001;
    end else if (run && count != 32'hFFFFFFFF) begin
      count <= count + 32'h00000001;
    end
  end
endmodule

// ===== verilog/timed_sequence_step_engine.v
// Timed step sequence engine with APB register access
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "step_timer_defs.vh"
module timed_sequence_step_engine (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg source_trigger,
  output reg seq_advance_trigger,
  output reg seq_done_event,
  output reg iter_complete_event,
  output reg timing_error,
  output reg busy
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam S_IDLE = 5'b00001;
  localparam S_WORK = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_NEXT = 5'b01000;
  localparam S_HALT = 5'b10000;

  reg [4:0] state_q;
  reg [31:0] ctrl_q;
  reg [31:0] step_period_q;
  reg [15:0] steps_q;
  reg [15:0] iters_q;
  reg [15:0] setup_q;
  reg [15:0] proptime_q;
  reg [15:0] rangetime_q;
  reg [31:0] stepcfg_mem [0:`MAX_STEPS-1];
  reg [3:0] cfg_idx_q;
  reg [3:0] step_q;
  reg [15:0] iter_q;
  reg [3:0] cur_range_q;
  reg range_valid_q;
  reg cfg_err_q;
  reg done_q;
  reg first_range_q;

  wire timed_step_enable = ctrl_q[`CTRL_TIMED];
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  wire [31:0] cfg = stepcfg_mem[step_q];
  wire [3:0] want_range = cfg[`STEPCFG_RANGE_MSB:`STEPCFG_RANGE_LSB];
  wire [3:0] props = cfg[`STEPCFG_PROPS_MSB:`STEPCFG_PROPS_LSB];
  wire range_change = ~range_valid_q | (want_range != cur_range_q);
  wire last_step = ({12'h000, step_q} == steps_q - 16'h0001);
  wire last_iter = (iter_q == iters_q - 16'h0001);
  wire final_step = last_step & last_iter;
  wire cmd_wr = apb_wr && paddr == `OFF_CMD;
  wire do_start = cmd_wr & pwdata[`CMD_START];
  wire do_abort = cmd_wr & pwdata[`CMD_ABORT];
  wire do_chan_reset = cmd_wr & pwdata[`CMD_CHAN_RESET];
  wire disable_wr = apb_wr && paddr == `OFF_CTRL && !pwdata[`CTRL_OUTPUT_ENABLE];
  wire clear_err = do_chan_reset | disable_wr;
  // Zero or oversized step counts would let the step index wrap and never finish; zero iterations would run 65536 passes
  wire count_bad = (steps_q == 16'h0000) || (steps_q > `MAX_STEPS) || (iters_q == 16'h0000);

  // Work of a step: setup, per-property programming, range change, delay, measure
  wire [31:0] work_len = {16'h0000, setup_q}
    + {16'h0000, proptime_q} * {28'h0000000, props}
    + (range_change ? {16'h0000, rangetime_q} : 32'h00000000)
    + {16'h0000, cfg[`STEPCFG_DELAY_MSB:`STEPCFG_DELAY_LSB]}
    + {24'h000000, cfg[`STEPCFG_MEAS_MSB:`STEPCFG_MEAS_LSB]};

  reg work_load;
  wire work_busy;
  wire work_done;
  wire step_restart;
  wire [31:0] elapsed;

  step_down_counter u_work (
    .pclk(pclk),
    .presetn(presetn),
    .load(work_load),
    .value(work_len),
    .clear(state_q == S_HALT || state_q == S_IDLE),
    .busy(work_busy),
    .expired(work_done)
  );

  period_counter u_period (
    .pclk(pclk),
    .presetn(presetn),
    .restart(step_restart),
    .run(state_q == S_WORK || state_q == S_WAIT),
    .count(elapsed)
  );

  assign step_restart = work_load;
  always @* begin
    work_load = (state_q == S_NEXT);
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
      step_period_q <= `PERIOD_RST;
      steps_q <= `STEPS_RST;
      iters_q <= `ITERS_RST;
      setup_q <= `SETUP_RST;
      proptime_q <= `PROPTIME_RST;
      rangetime_q <= `RANGETIME_RST;
      cfg_idx_q <= 4'h0;
    end else if (apb_wr) begin
      case (paddr)
        `OFF_CTRL: ctrl_q <= pwdata;
        `OFF_PERIOD: step_period_q <= pwdata;
        `OFF_STEPS: steps_q <= pwdata[15:0];
        `OFF_ITERS: iters_q <= pwdata[15:0];
        `OFF_SETUP: setup_q <= pwdata[15:0];
        `OFF_PROPTIME: proptime_q <= pwdata[15:0];
        `OFF_RANGETIME: rangetime_q <= pwdata[15:0];
        `OFF_STEPCFG: cfg_idx_q <= cfg_idx_q + 4'h1;
        `OFF_STATUS: cfg_idx_q <= 4'h0;
        default: cfg_idx_q <= cfg_idx_q;
      endcase
    end
  end

  // Step table has no reset; it is loaded by software before start
  // Writes past the last entry wrap onto entry zero
  always @(posedge pclk) begin
    if (apb_wr && paddr == `OFF_STEPCFG) begin
      stepcfg_mem[cfg_idx_q] <= pwdata;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      step_q <= 4'h0;
      iter_q <= 16'h0000;
      cur_range_q <= 4'h0;
      range_valid_q <= 1'b0;
      cfg_err_q <= 1'b0;
      done_q <= 1'b0;
      first_range_q <= 1'b0;
      source_trigger <= 1'b0;
      seq_advance_trigger <= 1'b0;
      seq_done_event <= 1'b0;
      iter_complete_event <= 1'b0;
      timing_error <= 1'b0;
      busy <= 1'b0;
    end else begin
      source_trigger <= 1'b0;
      seq_advance_trigger <= 1'b0;
      seq_done_event <= 1'b0;
      iter_complete_event <= 1'b0;
      if (clear_err) begin
        timing_error <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          busy <= 1'b0;
          if (do_start && !timing_error) begin
            if (timed_step_enable && ctrl_q[`CTRL_PULSED]) begin
              cfg_err_q <= 1'b1;
            end else if (count_bad) begin
              cfg_err_q <= 1'b1;
            end else begin
              cfg_err_q <= 1'b0;
              done_q <= 1'b0;
              step_q <= 4'h0;
              iter_q <= 16'h0000;
              busy <= 1'b1;
              state_q <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          // Step zero of the first iteration may overrun on a range change
          first_range_q <= range_change && step_q == 4'h0 && iter_q == 16'h0000;
          cur_range_q <= want_range;
          range_valid_q <= 1'b1;
          state_q <= S_WORK;
        end
        S_WORK: begin
          if (work_done) begin
            if (timed_step_enable && final_step) begin
              seq_done_event <= 1'b1;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end else if (timed_step_enable && elapsed > step_period_q
                         && !first_range_q) begin
              timing_error <= 1'b1;
              state_q <= S_HALT;
            end else if (timed_step_enable) begin
              state_q <= S_WAIT;
            end else begin
              state_q <= S_WAIT;
            end
          end
        end
        // The NEXT cycle adds one clock, so triggers sit one clock more than the period apart
        S_WAIT: begin
          if (!timed_step_enable || elapsed >= step_period_q || first_range_q) begin
            if (last_step) begin
              if (!timed_step_enable) begin
                iter_complete_event <= 1'b1;
              end
              if (last_iter) begin
                seq_done_event <= 1'b1;
                done_q <= 1'b1;
                state_q <= S_IDLE;
              end else begin
                step_q <= 4'h0;
                iter_q <= iter_q + 16'h0001;
                seq_advance_trigger <= 1'b1;
                state_q <= S_NEXT;
              end
            end else begin
              step_q <= step_q + 4'h1;
              source_trigger <= 1'b1;
              state_q <= S_NEXT;
            end
          end
        end
        S_HALT: begin
          if (clear_err) begin
            state_q <= S_IDLE;
            busy <= 1'b0;
          end
        end
        default: state_q <= S_IDLE;
      endcase
      // Abort leaves a halted error in place; only a clear releases it
      if (do_abort && state_q != S_HALT) begin
        state_q <= S_IDLE;
        busy <= 1'b0;
      end
      if (do_chan_reset) begin
        range_valid_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // APB read side, zero wait states
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Read data is latched in the setup cycle so it stands for the whole access
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `OFF_CTRL: prdata <= ctrl_q;
          `OFF_PERIOD: prdata <= step_period_q;
          `OFF_STEPS: prdata <= {16'h0000, steps_q};
          `OFF_ITERS: prdata <= {16'h0000, iters_q};
          `OFF_STATUS: prdata <= {28'h0000000, cfg_err_q, done_q, timing_error, busy};
          `OFF_CMD: prdata <= 32'h00000000;
          `OFF_STEPCFG: prdata <= {28'h0000000, cfg_idx_q};
          `OFF_SETUP: prdata <= {16'h0000, setup_q};
          `OFF_PROPTIME: prdata <= {16'h0000, proptime_q};
          `OFF_RANGETIME: prdata <= {16'h0000, rangetime_q};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ===== tb/timed_sequence_step_engine_sva.sv
// Port checker for the step engine
`timescale 1ns/10ps
`include "step_timer_defs.vh"
module timed_sequence_step_engine_sva (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic source_trigger,
  input logic seq_advance_trigger,
  input logic seq_done_event,
  input logic iter_complete_event,
  input logic timing_error,
  input logic busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Mode shadow
  // ----
  // Only ports are visible, so the mode bits are copied from CTRL writes
  logic timed_q;
  logic pulsed_q;
  wire wr = psel && penable && pwrite && pready;
  wire go = wr && paddr == `OFF_CMD && pwdata[`CMD_START];
  wire clr = wr && ((paddr == `OFF_CTRL && !pwdata[`CTRL_OUTPUT_ENABLE])
    || (paddr == `OFF_CMD && pwdata[`CMD_CHAN_RESET]));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timed_q <= 1'b0;
      pulsed_q <= 1'b0;
    end else if (wr && paddr == `OFF_CTRL) begin
      timed_q <= pwdata[`CTRL_TIMED];
      pulsed_q <= pwdata[`CTRL_PULSED];
    end
  end
  // ----
  // Assertions
  // ----
  err_timed_a: assert property ($rose(timing_error) |-> timed_q)
    else $error("error outside timed mode");
  err_sticky_a: assert property (timing_error && !clr |=> timing_error)
    else $error("error dropped");
  iter_quiet_a: assert property (iter_complete_event |-> !timed_q)
    else $error("iteration event in timed mode");
  done_clean_a: assert property (seq_done_event |-> !timing_error)
    else $error("done with error");
  trig_pulse_a: assert property (source_trigger |=> !source_trigger [*2])
    else $error("trigger too long");
  adv_excl_a: assert property (seq_advance_trigger |-> busy && !source_trigger)
    else $error("advance trigger clash");
  start_busy_a: assert property (go && !busy && !timing_error && !(timed_q && pulsed_q)
    |-> ##[2:3] busy)
    else $error("start ignored");
  pulse_refuse_a: assert property (go && timed_q && pulsed_q && !busy |=> !busy [*4])
    else $error("pulsed timed start ran");
  cover property (seq_advance_trigger);
  cover property (seq_done_event && timed_q);
  cover property ($rose(timing_error));
  cover property (iter_complete_event);
endmodule
bind timed_sequence_step_engine timed_sequence_step_engine_sva chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .source_trigger(source_trigger), .seq_advance_trigger(seq_advance_trigger),
  .seq_done_event(seq_done_event), .iter_complete_event(iter_complete_event),
  .timing_error(timing_error), .busy(busy));

// ===== tb/timed_sequence_step_engine_tb_top.sv
// Self-checking bench for the step engine
`timescale 1ns/10ps
`include "step_timer_defs.vh"
module timed_sequence_step_engine_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata;
  wire pready, pslverr, source_trigger, seq_advance_trigger, seq_done_event;
  wire iter_complete_event, timing_error, busy;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_src = 0, n_adv = 0, n_done = 0, n_iter = 0;
  int t_src, t_adv, t_done, t_go;
  int seed = 14;
  logic [64:0] exp_q[$];
  logic [11:0] ra [7] = '{`OFF_CTRL, `OFF_PERIOD, `OFF_STEPS, `OFF_ITERS, `OFF_SETUP,
    `OFF_PROPTIME, `OFF_RANGETIME};
  logic [31:0] rv [7] = '{`CTRL_RST, `PERIOD_RST, 32'(`STEPS_RST), 32'(`ITERS_RST),
    32'(`SETUP_RST), 32'(`PROPTIME_RST), 32'(`RANGETIME_RST)};
  timed_sequence_step_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .source_trigger(source_trigger),
    .seq_advance_trigger(seq_advance_trigger), .seq_done_event(seq_done_event),
    .iter_complete_event(iter_complete_event), .timing_error(timing_error), .busy(busy));
  initial forever #2 pclk = ~pclk;
  // ----
  // Stimulus tasks
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v, m, input logic e);
    exp_q.push_back({e, m, v});
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s exp %0h got %0h", nm, e, g);
      mismatches++;
    end
  endtask
  function automatic logic [31:0] stp(input logic [3:0] r, p, input logic [15:0] d);
    return {8'h03, d, p, r};
  endfunction
  // Writing STATUS rewinds the step table so both entries land at 0 and 1
  task automatic setup(input logic [31:0] c, p, n, it, s0, s1);
    apb(1'b1, `OFF_CTRL, c);
    apb(1'b1, `OFF_PERIOD, p);
    apb(1'b1, `OFF_STEPS, n);
    apb(1'b1, `OFF_ITERS, it);
    apb(1'b1, `OFF_STATUS, 32'h00000000);
    apb(1'b1, `OFF_STEPCFG, s0);
    apb(1'b1, `OFF_STEPCFG, s1);
  endtask
  task automatic run(input int s, a, d, e, i);
    int s0 = n_src;
    int a0 = n_adv;
    int d0 = n_done;
    int i0 = n_iter;
    apb(1'b1, `OFF_CMD, 32'h00000001);
    repeat (4) @(posedge pclk);
    for (int k = 0; k < 3000 && busy === 1'b1 && timing_error !== 1'b1; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk("triggers", s, n_src - s0);
    chk("advances", a, n_adv - a0);
    chk("done", d, n_done - d0);
    chk("iter", i, 32'(n_iter != i0));
    chk("error", e, 32'(timing_error));
  endtask
  // ----
  // Result monitor
  // ----
  always @(posedge pclk) begin
    logic [64:0] e;
    cyc++;
    if (source_trigger === 1'b1) begin
      n_src++;
      t_src = cyc;
    end
    if (seq_advance_trigger === 1'b1) begin
      n_adv++;
      t_adv = cyc;
    end
    if (seq_done_event === 1'b1) begin
      n_done++;
      t_done = cyc;
    end
    if (iter_complete_event === 1'b1) n_iter++;
    if (psel && penable && pready === 1'b1 && pwrite && paddr == `OFF_CMD && pwdata[0])
      t_go = cyc;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      n_tests++;
      if ((prdata & e[63:32]) !== e[31:0] || pslverr !== e[64]) begin
        $display("[FAIL] read %h exp %h got %h", paddr, e[31:0], prdata);
        mismatches++;
      end
    end
  end
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    complete_run;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i], 32'hFFFFFFFF, 1'b0);
    rd(12'h3FC, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    setup(32'h3, 32'h28, 32'h2, 32'h2, stp(4'h1, 4'h1, 16'($random(seed) & 7)),
      stp(4'h1, 4'h1, 16'($random(seed) & 7)));
    rd(`OFF_PERIOD, 32'h28, 32'hFFFFFFFF, 1'b0);
    run(2, 1, 1, 0, 0);
    chk("step time", 1, 32'(t_src - t_adv inside {[39:42]}));
    chk("last step", 1, 32'(t_done - t_src < 40));
    // Pass 0 overruns through a range change, pass 1 through property count
    // Two iterations keep the overrunning step off the exempt final step
    for (int k = 0; k < 2; k++) begin
      setup(32'h3, 32'h19, 32'h2, 32'h2, stp(4'h1, 4'h1, 16'h5),
        stp(k ? 4'h1 : 4'h2, k ? 4'h7 : 4'h1, 16'h5));
      run(1, 0, 0, 1, 0);
      apb(1'b1, `OFF_CMD, 32'h00000001);
      rd(`OFF_STATUS, 32'h2, 32'h2, 1'b0);
      apb(1'b1, `OFF_CMD, 32'h00000002);
      rd(`OFF_STATUS, 32'h2, 32'h2, 1'b0);
      apb(1'b1, k ? `OFF_CTRL : `OFF_CMD, k ? 32'h0 : 32'h4);
      repeat (2) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0, 32'h2, 1'b0);
    end
    setup(32'h3, 32'h19, 32'h2, 32'h1, stp(4'h2, 4'h1, 16'h5), stp(4'h2, 4'h1, 16'h5));
    run(1, 0, 1, 0, 0);
    chk("first step", 1, 32'(t_src - t_go > 27));
    // Preset the range with a single untimed point, abort, then run timed
    setup(32'h2, 32'h19, 32'h1, 32'h1, stp(4'h3, 4'h1, 16'h5), stp(4'h3, 4'h1, 16'h5));
    run(0, 0, 1, 0, 1);
    apb(1'b1, `OFF_CMD, 32'h00000002);
    setup(32'h3, 32'h19, 32'h2, 32'h1, stp(4'h3, 4'h1, 16'h5), stp(4'h3, 4'h1, 16'h5));
    run(1, 0, 1, 0, 0);
    chk("held step", 1, 32'(t_src - t_go inside {[26:28]}));
    setup(32'h2, 32'h19, 32'h1, 32'h2, stp(4'h2, 4'h1, 16'h5), stp(4'h2, 4'h1, 16'h5));
    run(0, 1, 1, 0, 1);
    setup(32'h5, 32'h19, 32'h1, 32'h1, stp(4'h2, 4'h1, 16'h5), stp(4'h2, 4'h1, 16'h5));
    apb(1'b1, `OFF_CMD, 32'h00000001);
    repeat (4) @(posedge pclk);
    rd(`OFF_STATUS, 32'h8, 32'h9, 1'b0);
    complete_run;
  end
endmodule
